// ---- rtl/imps_pkg.sv ----
// Register map, field layout and encodings of the indirect access and status slice
package imps_pkg;
    localparam int unsigned REG_W = 16;
    localparam int unsigned IDX_W = 8;
    localparam int unsigned BYTE_AW = 12;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CTRL = 8'h0d;
    localparam logic [IDX_W-1:0] IDX_ADDR_DATA = 8'h0e;
    localparam logic [IDX_W-1:0] IDX_STATUS = 8'h10;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 8'h12;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'h13;

    // Indirect control fields
    localparam int unsigned CMD_HI = 15;
    localparam int unsigned CMD_LO = 14;
    localparam int unsigned SEL_HI = 4;
    localparam int unsigned SEL_LO = 0;
    localparam int unsigned SEL_W = 5;
    localparam logic [SEL_W-1:0] SPACE_STD = 5'h01;
    localparam logic [SEL_W-1:0] SPACE_VENDOR = 5'h1f;
    localparam logic [REG_W-1:0] VENDOR_TOP = 16'h04d1;
    localparam logic [REG_W-1:0] CTRL_RESET = 16'h0000;
    localparam logic [REG_W-1:0] ADDR_DATA_RESET = 16'h0000;
    localparam logic [REG_W-1:0] PTR_STEP = 16'h0001;

    typedef enum logic [1:0] {
        IMPS_CMD_ADDR = 2'h0,
        IMPS_CMD_DATA = 2'h1,
        IMPS_CMD_INC_RW = 2'h2,
        IMPS_CMD_INC_W = 2'h3
    } imps_cmd_t;

    // Status fields
    localparam int unsigned ST_CHAN = 10;
    localparam int unsigned ST_LOCK = 9;
    localparam int unsigned ST_PIN = 7;
    localparam int unsigned ST_LOOP = 3;
    localparam int unsigned ST_DUPLEX = 2;
    localparam int unsigned ST_LINK = 0;
    localparam logic [REG_W-1:0] STATUS_RESET = 16'h0004;

    // Latched-low flag order inside the latch vector
    localparam int unsigned LL_CHAN = 0;
    localparam int unsigned LL_LOCK = 1;
    localparam int unsigned LL_LINK = 2;
    localparam int unsigned LL_W = 3;

    // Interrupt event bits
    localparam int unsigned EV_CHAN_LOST = 0;
    localparam int unsigned EV_LOCK_LOST = 1;
    localparam int unsigned EV_LINK_DOWN = 2;
    localparam int unsigned EV_LINK_UP = 3;
    localparam int unsigned EV_W = 4;
    localparam logic [EV_W-1:0] IRQ_MASK_RESET = 4'h0;

    function automatic logic [BYTE_AW-1:0] idx_to_byte(input logic [IDX_W-1:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction
endpackage

// ---- rtl/imps_latch_low.sv ----
// Latched-low condition flags, reloaded with the live value on a read
`timescale 1ns/10ps
module imps_latch_low
    import imps_pkg::*;
#(
    parameter int unsigned W = 3
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Conditions and read strobe
    input wire logic [W-1:0] live,
    input wire logic rd_clr,
    // Latched view
    output logic [W-1:0] q
);
    logic [W-1:0] next_q;

    if (W < 1) begin : g_chk
        $error("imps_latch_low needs W of at least 1");
    end

    always_comb begin
        next_q = q;
        if (ce) begin
            // reload on read
            // The reload copies the live value, so a loss during the read is kept
            next_q = rd_clr ? live : (q & live);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
endmodule

// ---- rtl/imps_irq.sv ----
// Sticky interrupt status with write-one-to-clear and masked level output
`timescale 1ns/10ps
module imps_irq
    import imps_pkg::*;
#(
    parameter int unsigned W = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Events and software access
    input wire logic [W-1:0] evt,
    input wire logic wr_clr,
    input wire logic [W-1:0] clr_bits,
    input wire logic [W-1:0] mask,
    // Results
    output logic [W-1:0] status,
    output logic irq
);
    logic [W-1:0] next_status;

    if (W < 1) begin : g_chk
        $error("imps_irq needs W of at least 1");
    end

    always_comb begin
        next_status = status;
        if (ce) begin
            // Set wins over a clear in the same cycle
            next_status = (status & ~(wr_clr ? clr_bits : '0)) | evt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end

    assign irq = |(status & mask);
endmodule

// ---- rtl/imps_top.sv ----
// APB register slice: indirect extended-space access and link status
//
// Functional notes
// - Command 0 makes address/data a pointer; command 1 a data port, no increment.
// - Command 2 increments the pointer after every data read and write.
// - Command 3 increments the pointer after data writes only.
// - Five-bit space select steers every indirect access.
// - Select all ones reaches the vendor space; the pointer is not limited to 0x04d1.
// - Select 00001 reaches standard device space one.
// - Other select codes: indirect accesses ignored, writes change nothing.
// - Address/data holds the pointer in command 0, otherwise the data.
// - Status bit 10: channel ok, latched low.
// - Status bit 9: descrambler lock, latched low.
// - Status bit 7 set once interrupt asserted; cleared by reading register 0x12.
// - Status bit 2 shows duplex, 1 full; resets to 1.
// - Status bit 0 shows link, latched low; resets to 0.
`timescale 1ns/10ps
module imps_top
    import imps_pkg::*;
#(
    parameter int unsigned APB_AW = 12
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic [APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Live PHY conditions
    input wire logic channel_ok,
    input wire logic descr_lock,
    input wire logic link_up,
    input wire logic mac_loopback,
    input wire logic full_duplex,
    // Extended register space
    output logic [SEL_W-1:0] mmd_space,
    output logic [REG_W-1:0] mmd_addr,
    input wire logic [REG_W-1:0] mmd_rdata,
    output logic mmd_wr,
    output logic [SEL_W-1:0] mmd_wspace,
    output logic [REG_W-1:0] mmd_waddr,
    output logic [REG_W-1:0] mmd_wdata,
    // Interrupt
    output logic irq
);
    if (APB_AW < BYTE_AW) begin : g_chk
        $error("imps_top needs APB_AW of at least 12");
    end

    function automatic logic hit(input logic [APB_AW-1:0] a, input logic [IDX_W-1:0] idx);
        return a == APB_AW'(idx_to_byte(idx));
    endfunction

    // Byte-lane merge of a 16-bit register with APB write data
    function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old,
                                                 input logic [31:0] wd,
                                                 input logic [3:0] st);
        logic [REG_W-1:0] r;
        r = old;
        if (st[0]) begin
            r[7:0] = wd[7:0];
        end
        if (st[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    // Registers
    imps_cmd_t cmd;
    logic [SEL_W-1:0] space_select;
    logic [REG_W-1:0] ptr [2];
    logic [EV_W-1:0] irq_mask;
    logic pin_flag;
    logic duplex_q;
    logic loop_q;
    logic [LL_W-1:0] prev_live;
    imps_cmd_t next_cmd;
    logic [SEL_W-1:0] next_space_select;
    logic [REG_W-1:0] next_ptr [2];
    logic [EV_W-1:0] next_irq_mask;
    logic next_pin_flag;
    logic next_duplex_q;
    logic next_loop_q;
    logic [LL_W-1:0] next_prev_live;
    logic [31:0] next_prdata;
    logic next_mmd_wr;
    logic [SEL_W-1:0] next_mmd_wspace;
    logic [REG_W-1:0] next_mmd_waddr;
    logic [REG_W-1:0] next_mmd_wdata;

    // Decode
    logic setup;
    logic access;
    logic wr_acc;
    logic rd_acc;
    logic mapped;
    logic sel_ok;
    logic sp;
    logic [REG_W-1:0] cur_ptr;
    logic data_mode;
    logic ad_wr;
    logic ad_rd;
    logic [REG_W-1:0] ad_wval;
    logic [LL_W-1:0] live;
    logic [LL_W-1:0] latched;
    logic [EV_W-1:0] evt;
    logic [EV_W-1:0] irq_status;
    logic [REG_W-1:0] status_word;
    logic [REG_W-1:0] ctrl_wval;
    logic [REG_W-1:0] mask_wval;
    logic st_rd;

    assign setup = psel && !penable && ce;
    assign access = psel && penable && ce;
    assign wr_acc = access && pwrite;
    assign rd_acc = access && !pwrite;
    assign mapped = hit(paddr, IDX_CTRL) || hit(paddr, IDX_ADDR_DATA) ||
                    hit(paddr, IDX_STATUS) || hit(paddr, IDX_IRQ_STATUS) ||
                    hit(paddr, IDX_IRQ_MASK);
    // Frozen block holds the bus off instead of losing a transfer
    assign pready = ce;
    assign pslverr = access && !mapped;

    // Space filter
    assign sel_ok = (space_select == SPACE_STD) || (space_select == SPACE_VENDOR);
    assign sp = (space_select == SPACE_VENDOR);
    assign cur_ptr = ptr[sp];
    assign data_mode = (cmd != IMPS_CMD_ADDR);
    assign ad_wr = wr_acc && hit(paddr, IDX_ADDR_DATA) && sel_ok;
    assign ad_rd = rd_acc && hit(paddr, IDX_ADDR_DATA) && sel_ok;
    assign ad_wval = merge16(data_mode ? mmd_rdata : cur_ptr, pwdata, pstrb);
    assign ctrl_wval = merge16({cmd, 9'h000, space_select}, pwdata, pstrb);
    assign mask_wval = merge16({12'h000, irq_mask}, pwdata, pstrb);
    assign st_rd = rd_acc && hit(paddr, IDX_STATUS);
    // Read port follows the selected pointer; VENDOR_TOP does not bound the vendor range
    assign mmd_space = space_select;
    assign mmd_addr = cur_ptr;

    assign live[LL_CHAN] = channel_ok;
    assign live[LL_LOCK] = descr_lock;
    assign live[LL_LINK] = link_up;

    // Channel, lock and link latch low
    imps_latch_low #(
        .W(LL_W)
    ) u_latch (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .live(live),
        .rd_clr(st_rd),
        .q(latched)
    );

    assign evt[EV_CHAN_LOST] = prev_live[LL_CHAN] && !channel_ok;
    assign evt[EV_LOCK_LOST] = prev_live[LL_LOCK] && !descr_lock;
    assign evt[EV_LINK_DOWN] = prev_live[LL_LINK] && !link_up;
    assign evt[EV_LINK_UP] = !prev_live[LL_LINK] && link_up;

    imps_irq #(
        .W(EV_W)
    ) u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .evt(evt),
        .wr_clr(wr_acc && hit(paddr, IDX_IRQ_STATUS)),
        .clr_bits(pwdata[EV_W-1:0]),
        .mask(irq_mask),
        .status(irq_status),
        .irq(irq)
    );

    always_comb begin
        status_word = '0;
        status_word[ST_CHAN] = latched[LL_CHAN];
        status_word[ST_LOCK] = latched[LL_LOCK];
        status_word[ST_PIN] = pin_flag;
        status_word[ST_LOOP] = loop_q;
        status_word[ST_DUPLEX] = duplex_q;
        status_word[ST_LINK] = latched[LL_LINK];
    end

    always_comb begin
        next_cmd = cmd;
        next_space_select = space_select;
        next_ptr = ptr;
        next_irq_mask = irq_mask;
        next_pin_flag = pin_flag;
        next_duplex_q = duplex_q;
        next_loop_q = loop_q;
        next_prev_live = prev_live;
        next_prdata = prdata;
        next_mmd_wr = 1'b0;
        next_mmd_wspace = mmd_wspace;
        next_mmd_waddr = mmd_waddr;
        next_mmd_wdata = mmd_wdata;
        if (ce) begin
            next_prev_live = live;
            next_loop_q = mac_loopback;
            next_duplex_q = full_duplex;
            if (wr_acc && hit(paddr, IDX_CTRL)) begin
                next_cmd = imps_cmd_t'(ctrl_wval[CMD_HI:CMD_LO]);
                next_space_select = ctrl_wval[SEL_HI:SEL_LO];
            end
            if (wr_acc && hit(paddr, IDX_IRQ_MASK)) begin
                next_irq_mask = mask_wval[EV_W-1:0];
            end
            if (ad_wr) begin
                unique case (cmd)
                    IMPS_CMD_ADDR: begin
                        next_ptr[sp] = ad_wval;
                    end
                    IMPS_CMD_DATA: begin
                        next_mmd_wr = 1'b1;
                    end
                    IMPS_CMD_INC_RW, IMPS_CMD_INC_W: begin
                        next_mmd_wr = 1'b1;
                        next_ptr[sp] = cur_ptr + PTR_STEP;
                    end
                endcase
                next_mmd_wspace = space_select;
                next_mmd_waddr = cur_ptr;
                next_mmd_wdata = ad_wval;
            end
            // read increment only in command 2
            if (ad_rd && cmd == IMPS_CMD_INC_RW) begin
                next_ptr[sp] = cur_ptr + PTR_STEP;
            end
            // set on interrupt, cleared by reading 0x12, set wins
            if (rd_acc && hit(paddr, IDX_IRQ_STATUS)) begin
                next_pin_flag = 1'b0;
            end
            if (irq) begin
                next_pin_flag = 1'b1;
            end
            if (setup && !pwrite) begin
                next_prdata = '0;
                if (hit(paddr, IDX_CTRL)) begin
                    next_prdata[CMD_HI:CMD_LO] = cmd;
                    next_prdata[SEL_HI:SEL_LO] = space_select;
                end else if (hit(paddr, IDX_ADDR_DATA)) begin
                    if (sel_ok) begin
                        next_prdata[REG_W-1:0] = data_mode ? mmd_rdata : cur_ptr;
                    end
                end else if (hit(paddr, IDX_STATUS)) begin
                    next_prdata[REG_W-1:0] = status_word;
                end else if (hit(paddr, IDX_IRQ_STATUS)) begin
                    next_prdata[EV_W-1:0] = irq_status;
                end else if (hit(paddr, IDX_IRQ_MASK)) begin
                    next_prdata[EV_W-1:0] = irq_mask;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd <= imps_cmd_t'(CTRL_RESET[CMD_HI:CMD_LO]);
            space_select <= CTRL_RESET[SEL_HI:SEL_LO];
            ptr[0] <= ADDR_DATA_RESET;
            ptr[1] <= ADDR_DATA_RESET;
            irq_mask <= IRQ_MASK_RESET;
            pin_flag <= STATUS_RESET[ST_PIN];
            duplex_q <= STATUS_RESET[ST_DUPLEX];
            loop_q <= STATUS_RESET[ST_LOOP];
            prev_live <= '0;
            prdata <= '0;
            mmd_wr <= 1'b0;
            mmd_wspace <= '0;
            mmd_waddr <= '0;
            mmd_wdata <= '0;
        end else begin
            cmd <= next_cmd;
            space_select <= next_space_select;
            ptr <= next_ptr;
            irq_mask <= next_irq_mask;
            pin_flag <= next_pin_flag;
            duplex_q <= next_duplex_q;
            loop_q <= next_loop_q;
            prev_live <= next_prev_live;
            prdata <= next_prdata;
            mmd_wr <= next_mmd_wr;
            mmd_wspace <= next_mmd_wspace;
            mmd_waddr <= next_mmd_waddr;
            mmd_wdata <= next_mmd_wdata;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_addr_no_write;
        ad_wr && cmd == IMPS_CMD_ADDR |=> !mmd_wr && mmd_addr == $past(ad_wval);
    endproperty
    a_addr_no_write: assert property (p_addr_no_write) else $error("pointer load misbehaved");

    property p_inc_rw_read;
        ad_rd && cmd == IMPS_CMD_INC_RW |=> cur_ptr == REG_W'($past(cur_ptr) + PTR_STEP);
    endproperty
    a_inc_rw_read: assert property (p_inc_rw_read) else $error("read did not advance");

    property p_inc_w_read;
        ad_rd && cmd != IMPS_CMD_INC_RW |=> cur_ptr == $past(cur_ptr);
    endproperty
    a_inc_w_read: assert property (p_inc_w_read) else $error("read moved pointer");

    property p_data_write;
        ad_wr && data_mode |=> mmd_wr && mmd_waddr == $past(cur_ptr) ##1 !mmd_wr;
    endproperty
    a_data_write: assert property (p_data_write) else $error("data write not issued");

    property p_ignored;
        wr_acc && hit(paddr, IDX_ADDR_DATA) && !sel_ok
            |=> !mmd_wr && ptr[0] == $past(ptr[0]) && ptr[1] == $past(ptr[1]);
    endproperty
    a_ignored: assert property (p_ignored) else $error("filtered write took effect");

    property p_routed;
        mmd_wr |-> mmd_wspace == SPACE_STD || mmd_wspace == SPACE_VENDOR;
    endproperty
    a_routed: assert property (p_routed) else $error("write to unsupported space");

    property p_chan_low;
        ce && !channel_ok |=> !latched[LL_CHAN] ##1 (!latched[LL_CHAN] || $past(st_rd));
    endproperty
    a_chan_low: assert property (p_chan_low) else $error("channel drop not latched");

    property p_lock_low;
        ce && !descr_lock |=> !status_word[ST_LOCK];
    endproperty
    a_lock_low: assert property (p_lock_low) else $error("lock loss not latched");

    property p_pin;
        ce && irq |=> pin_flag;
    endproperty
    a_pin: assert property (p_pin) else $error("pin flag missed interrupt");

    property p_reload;
        rd_acc && hit(paddr, IDX_STATUS) && link_up |=> latched[LL_LINK];
    endproperty
    a_reload: assert property (p_reload) else $error("link flag not reloaded");

    property p_duplex;
        ce |=> status_word[ST_DUPLEX] == $past(full_duplex);
    endproperty
    a_duplex: assert property (p_duplex) else $error("duplex view stale");
endmodule

// ---- dv/imps_mmd_model.sv ----
// Extended register space stand-in for the indirect access port
`timescale 1ns/10ps
module imps_mmd_model
    import imps_pkg::*;
(
    // Clock
    input wire logic pclk,
    // Read side
    input wire logic [SEL_W-1:0] space,
    input wire logic [REG_W-1:0] addr,
    output logic [REG_W-1:0] rdata,
    // Write side
    input wire logic wr,
    input wire logic [SEL_W-1:0] wspace,
    input wire logic [REG_W-1:0] waddr,
    input wire logic [REG_W-1:0] wdata
);
    logic [REG_W-1:0] mem [2][16];
    logic [REG_W-1:0] noise;

    initial begin
        noise = 16'h5a5a;
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < 16; i++) begin
                mem[s][i] = {s[0] ? 8'hb0 : 8'ha0, 4'h0, i[3:0]};
            end
        end
    end

    // two spaces answer
    // Unselected spaces churn so a stale value never passes
    always_comb begin
        if (space == SPACE_STD || space == SPACE_VENDOR) begin
            rdata = mem[space == SPACE_VENDOR][addr[3:0]];
        end else begin
            rdata = noise;
        end
    end

    always @(posedge pclk) begin
        noise <= ~noise + 16'h0001;
        if (wr && (wspace == SPACE_STD || wspace == SPACE_VENDOR)) begin
            mem[wspace == SPACE_VENDOR][waddr[3:0]] <= wdata;
        end
    end
endmodule

// ---- dv/imps_top_test.sv ----
// Self-checking bench for the indirect access and status slice
`timescale 1ns/10ps
module imps_top_test
    import imps_pkg::*;
;
    localparam logic [11:0] CT = 12'h034;
    localparam logic [11:0] AD = 12'h038;
    localparam logic [11:0] ST = 12'h040;
    localparam logic [11:0] IS = 12'h048;
    localparam logic [11:0] IM = 12'h04c;
    localparam logic [15:0] CL [3] = '{16'h0400, 16'h0200, 16'h0001};
    localparam logic [3:0] EV [3] = '{4'h1, 4'h2, 4'hc};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, mmd_wr, lb, dx, rerr, ce;
    logic [3:0] st;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [2:0] lv;
    logic [SEL_W-1:0] mmd_space, mmd_wspace;
    logic [REG_W-1:0] mmd_addr, mmd_rdata, mmd_waddr, mmd_wdata;
    int failures, num_checks, nwr;

    imps_top dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(st), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .channel_ok(lv[0]), .descr_lock(lv[1]),
        .link_up(lv[2]), .mac_loopback(lb), .full_duplex(dx), .mmd_space(mmd_space),
        .mmd_addr(mmd_addr), .mmd_rdata(mmd_rdata), .mmd_wr(mmd_wr),
        .mmd_wspace(mmd_wspace), .mmd_waddr(mmd_waddr), .mmd_wdata(mmd_wdata), .irq(irq));

    imps_mmd_model far_u (.pclk(pclk), .space(mmd_space), .addr(mmd_addr),
        .rdata(mmd_rdata), .wr(mmd_wr), .wspace(mmd_wspace), .waddr(mmd_waddr),
        .wdata(mmd_wdata));

    always @(posedge pclk) begin
        if (mmd_wr === 1'b1) nwr++;
    end

    task automatic print_verdict;
        if (failures == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // No wait-state count assumed; the watchdog ends a hang
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [15:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, {16'h0, e});
    endtask

    function automatic logic [31:0] ctl(input logic [1:0] c, input logic [4:0] s);
        return {16'h0, c, 9'h0, s};
    endfunction

    function automatic logic [15:0] fv(input logic v, input logic [3:0] i);
        return {v ? 8'hb0 : 8'ha0, 4'h0, i};
    endfunction

    task automatic t_reset;
        rchk(CT, 16'h0000);
        rchk(AD, 16'h0000);
        rchk(IM, 16'h0000);
        rchk(ST, 16'h0004);
        rchk(ST, 16'h0605);
        apb(1'b0, 12'h0f0, 32'h0);
        chk(rerr, 1'b1);
        chk(rdat, 32'h0);
    endtask

    task automatic t_ind(input logic [4:0] sp, input logic v);
        int n0;
        n0 = nwr;
        apb(1'b1, CT, ctl(2'h0, sp));
        apb(1'b1, AD, 32'h2);
        rchk(AD, 16'h0002);
        apb(1'b1, CT, ctl(2'h1, sp));
        rchk(AD, fv(v, 4'h2));
        rchk(AD, fv(v, 4'h2));
        chk(mmd_space, sp);
        apb(1'b1, AD, {16'h0, 8'hc0, 3'h0, sp});
        rchk(AD, {8'hc0, 3'h0, sp});
        apb(1'b1, CT, ctl(2'h2, sp));
        rchk(AD, {8'hc0, 3'h0, sp});
        rchk(AD, fv(v, 4'h3));
        apb(1'b1, AD, 32'h00d4);
        apb(1'b1, CT, ctl(2'h3, sp));
        rchk(AD, fv(v, 4'h5));
        rchk(AD, fv(v, 4'h5));
        apb(1'b1, AD, 32'h00e5);
        apb(1'b1, CT, ctl(2'h0, sp));
        rchk(AD, 16'h0006);
        apb(1'b1, AD, 32'h4);
        apb(1'b1, CT, ctl(2'h2, sp));
        rchk(AD, 16'h00d4);
        rchk(AD, 16'h00e5);
        chk(nwr, n0 + 3);
        apb(1'b1, CT, ctl(2'h0, sp));
    endtask

    task automatic t_space;
        apb(1'b1, AD, 32'h04d1);
        rchk(AD, 16'h04d1);
        apb(1'b1, CT, ctl(2'h1, SPACE_VENDOR));
        rchk(AD, fv(1'b1, 4'h1));
        apb(1'b1, CT, ctl(2'h0, SPACE_STD));
        rchk(AD, 16'h0006);
    endtask

    task automatic t_bad;
        int n0;
        n0 = nwr;
        for (int s = 0; s < 31; s += 15) begin
            apb(1'b1, CT, ctl(2'h2, s[4:0]));
            apb(1'b1, AD, 32'h0bad);
            rchk(AD, 16'h0000);
        end
        chk(nwr, n0);
        apb(1'b1, CT, ctl(2'h0, SPACE_STD));
        rchk(AD, 16'h0006);
    endtask

    task automatic t_latch;
        for (int b = 0; b < 3; b++) begin
            apb(1'b1, IS, 32'hf);
            rchk(IS, 16'h0000);
            @(posedge pclk);
            lv <= 3'b111 ^ (3'b001 << b);
            @(posedge pclk);
            lv <= 3'b111;
            rchk(ST, 16'h0605 ^ CL[b]);
            rchk(ST, 16'h0605);
            rchk(IS, {12'h0, EV[b]});
        end
        lv <= 3'b110;
        @(posedge pclk);
        rchk(ST, 16'h0205);
        lv <= 3'b111;
        rchk(ST, 16'h0205);
        rchk(ST, 16'h0605);
        lb <= 1'b1;
        dx <= 1'b0;
        @(posedge pclk);
        rchk(ST, 16'h0609);
        lb <= 1'b0;
        dx <= 1'b1;
        @(posedge pclk);
        rchk(ST, 16'h0605);
    endtask

    task automatic t_irq;
        apb(1'b1, IS, 32'hf);
        apb(1'b1, IM, 32'h1);
        rchk(IM, 16'h0001);
        chk(irq, 1'b0);
        lv <= 3'b110;
        @(posedge pclk);
        lv <= 3'b111;
        @(posedge pclk);
        chk(irq, 1'b1);
        apb(1'b1, IS, 32'h1);
        @(posedge pclk);
        chk(irq, 1'b0);
        lv <= 3'b101;
        @(posedge pclk);
        lv <= 3'b111;
        @(posedge pclk);
        chk(irq, 1'b0);
        rchk(ST, 16'h0085);
        rchk(IS, 16'h0002);
        rchk(ST, 16'h0605);
    endtask

    // Upper lane only merges into the data word; a frozen block ignores a drop
    task automatic t_freeze;
        apb(1'b1, CT, ctl(2'h1, SPACE_STD));
        st <= 4'h2;
        apb(1'b1, AD, 32'h7788);
        st <= 4'hf;
        rchk(AD, 16'h7706);
        ce <= 1'b0;
        lv <= 3'b110;
        @(posedge pclk);
        @(posedge pclk);
        chk(pready, 1'b0);
        ce <= 1'b1;
        lv <= 3'b111;
        rchk(ST, 16'h0605);
    endtask

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        failures++;
        print_verdict;
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        lv = 3'b111;
        lb = 1'b0;
        dx = 1'b1;
        ce = 1'b1;
        st = 4'hf;
        failures = 0;
        num_checks = 0;
        nwr = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_ind(SPACE_STD, 1'b0);
        t_ind(SPACE_VENDOR, 1'b1);
        t_space;
        t_bad;
        t_latch;
        t_irq;
        t_freeze;
        print_verdict;
    end
endmodule
